// ---- common/prd_params.svh ----
// field positions, power-up values and timing counts.
// assumes a 40 MHz mclk, 32-bit words, address in [3:0].
//
// Behaviour
// - oscillator runs while enable bit set, ce high
// - host clears enable bit for CMOS oscillator
// - two-bit bias field sets oscillator bias
// - clock output 50:50, inverted to reference
// - clock output divides by even 2..30
// - clock output defaults to divide-by-8
// - divide field zero disables clock output
// - three-bit R divider feeds phase detector
// - R divider defaults to one
// - feedback: 8-bit integer, 15-bit fraction
// - host never programs integer below 23
// - output is pd rate times int+frac/2^15
// - halving option multiplies output by half
// - host keeps integer at most 255
// - ce low clears all configuration
// - host writes only with ce high, ready
// - three-bit select routes status to pin
// - regulator-ready is default status selection
// - ready rises 50 us; host waits for it
// - calibration-complete low during calibrations
// - lock after five good cycles, lost at 25ns
`ifndef PRD_PARAMS_SVH
`define PRD_PARAMS_SVH

// ***************************************************************
// word layout
// ***************************************************************
`define PRD_ADDR_MSB    3
`define PRD_ADDR_LSB    0
`define PRD_REG0_ADDR   4'h0
`define PRD_REG1_ADDR   4'h1
`define PRD_FRAC_MSB    18
`define PRD_FRAC_LSB    4
`define PRD_INT_MSB     26
`define PRD_INT_LSB     19
`define PRD_MUX_MSB     31
`define PRD_MUX_LSB     29
`define PRD_RDIV_MSB    6
`define PRD_RDIV_LSB    4
`define PRD_CKDIV_MSB   10
`define PRD_CKDIV_LSB   7
`define PRD_OSCEN_BIT   12
`define PRD_BIAS_MSB    14
`define PRD_BIAS_LSB    13
`define PRD_HALVE_BIT   18

// ***************************************************************
// power-up values
// ***************************************************************
`define PRD_RST_RDIV    3'h1
`define PRD_RST_CKDIV   4'h4
`define PRD_RST_OSCEN   1'b1
`define PRD_RST_BIAS    2'h0
`define PRD_RST_HALVE   1'b0
`define PRD_RST_MUX     3'h0
`define PRD_RST_INT     8'h00
`define PRD_RST_FRAC    15'h0000

// ***************************************************************
// timing
// ***************************************************************
`define PRD_CLK_MHZ     40
`define PRD_RDY_US      50
`define PRD_RDY_CYCLES  (`PRD_RDY_US * `PRD_CLK_MHZ)
`define PRD_LOCK_IN_NS  15
`define PRD_LOCK_OUT_NS 25
`define PRD_LOCK_RUN    5
`define PRD_INT_MIN     23
`define PRD_SCLK_HALF   4

`endif

// ---- common/prd_pkg.sv ----
// types shared by both ends of the link.
// assumes prd_params.svh holds the numbers.
package prd_pkg;

   // ************************************************************
   // status pin selections
   // ************************************************************
   typedef enum logic [2:0]
   {
      PRD_MUX_REG_READY  = 3'b000,
      PRD_MUX_FILTER_CAL = 3'b001,
      PRD_MUX_LOCK       = 3'b010,
      PRD_MUX_RSSI       = 3'b011,
      PRD_MUX_TX_RX      = 3'b100
   } prd_mux_type;

   typedef enum logic [1:0]
   {
      PRD_H_IDLE  = 2'b00,
      PRD_H_SHIFT = 2'b01,
      PRD_H_LATCH = 2'b10
   } prd_hstate_type;

   // ************************************************************
   // module state
   // ************************************************************
   typedef struct packed
   {
      logic [1:0]  ce_s;
      logic [1:0]  sclk_s;
      logic [1:0]  sdat_s;
      logic [1:0]  sle_s;
      logic        sclk_d;
      logic        sle_d;
      logic [31:0] shift;
      logic [2:0]  mux_sel;
      logic [7:0]  int_n;
      logic [14:0] frac_n;
      logic [2:0]  rdiv;
      logic [3:0]  ckdiv;
      logic        osc_en;
      logic [1:0]  bias;
      logic        halve;
      logic        osc_run;
      logic [11:0] rdy_cnt;
      logic        reg_ready;
      logic [2:0]  rcnt;
      logic        pd_tick;
      logic [2:0]  lock_cnt;
      logic        locked;
      logic [14:0] acc;
      logic [8:0]  fb_ratio;
      logic        status;
   } prd_dev_state_type;

   typedef struct packed
   {
      prd_hstate_type st;
      logic           ce;
      logic           sclk;
      logic           sdata;
      logic           sle;
      logic [31:0]    word;
      logic [4:0]     bitcnt;
      logic [7:0]     divcnt;
      logic [1:0]     stat_s;
      logic [2:0]     sel;
      logic [2:0]     pend_sel;
      logic           pend_is0;
      logic           rdy;
      logic           ready_o;
      logic           done;
      logic           refused;
   } prd_host_state_type;

   typedef struct packed
   {
      logic [3:0] cnt;
      logic       out;
   } prd_ck_state_type;

endpackage

// ---- common/prd_link_if.sv ----
// pins between the host and device ends.
// assumes one mclk; the device resynchronises.
`timescale 1ns/1ps
interface prd_link_if;
   logic ce;
   logic sclk;
   logic sdata;
   logic sle;
   logic status_select_pin;
   logic divided_ref_clock_output;

   modport dev
   (
      input  ce,
      input  sclk,
      input  sdata,
      input  sle,
      output status_select_pin,
      output divided_ref_clock_output
   );

   modport host
   (
      output ce,
      output sclk,
      output sdata,
      output sle,
      input  status_select_pin,
      input  divided_ref_clock_output
   );
endinterface

// ---- rtl/prd_divided_ref_clock_output_div.sv ----
// divided reference clock: toggles every div cycles.
// assumes mclk is the reference.
`timescale 1ns/1ps
module prd_divided_ref_clock_output_div
   import prd_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire logic       run,
   input  wire logic [3:0] div,
   output      logic       clk_out
);
   prd_ck_state_type q;
   prd_ck_state_type n;

   always_comb
   begin
      n = q;
      if (!run || div == 4'h0)
      begin
         // parked past terminal count so the first edge rises
         n.cnt = 4'hf;
         n.out = 1'b0;
      end
      else if (q.cnt >= div - 4'h1)
      begin
         n.cnt = 4'h0;
         n.out = ~q.out;
      end
      else
      begin
         n.cnt = q.cnt + 4'h1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   assign clk_out = q.out;
endmodule

// ---- rtl/prd_device.sv ----
// device end: serial configuration latch, regulator-ready timer,
// R and fractional N dividers, lock detect and status pin selector.
// assumes mclk is the reference clock; analogue inputs share mclk.
`timescale 1ns/1ps
`include "prd_params.svh"
module prd_device
   import prd_pkg::*;
#(
   parameter int READY_CYCLES = `PRD_RDY_CYCLES
)
(
   input  wire logic        mclk,
   input  wire logic        reset,
   prd_link_if.dev          link,
   input  wire logic [7:0]  phase_err_ns,
   input  wire logic        filter_cal_busy,
   input  wire logic        rssi_ready,
   input  wire logic        tx_mode,
   output      logic        osc_run,
   output      logic [1:0]  oscillator_bias_field,
   output      logic        pd_ref_tick,
   output      logic [7:0]  int_count,
   output      logic [14:0] frac_value,
   output      logic        output_halving_select,
   output      logic [8:0]  fb_divide,
   output      logic        lock_detect
);
   generate
      if (READY_CYCLES < 1 || READY_CYCLES > 4095)
      begin : g_bad_ready
         $error("READY_CYCLES out of range 1..4095");
      end
   endgenerate

   prd_dev_state_type q;
   prd_dev_state_type n;

   // ************************************************************
   // power-up and power-down values
   // ************************************************************
   function automatic prd_dev_state_type dev_defaults();
      prd_dev_state_type s;
      s         = '0;
      s.rdiv    = `PRD_RST_RDIV;
      s.ckdiv   = `PRD_RST_CKDIV;
      s.osc_en  = `PRD_RST_OSCEN;
      s.bias    = `PRD_RST_BIAS;
      s.halve   = `PRD_RST_HALVE;
      s.mux_sel = `PRD_RST_MUX;
      s.int_n   = `PRD_RST_INT;
      s.frac_n  = `PRD_RST_FRAC;
      return s;
   endfunction

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      logic [15:0] fsum;
      logic [2:0]  rlim;
      logic [3:0]  addr;
      fsum = {1'b0, q.acc} + {1'b0, q.frac_n};
      rlim = (q.rdiv == 3'h0) ? 3'h1 : q.rdiv;
      addr = q.shift[`PRD_ADDR_MSB:`PRD_ADDR_LSB];
      n = q;
      n.pd_tick = 1'b0;
      if (!q.ce_s[1])
      begin
         // regulators off: every stored field returns to its default
         n = dev_defaults();
      end
      else
      begin
         if (!q.reg_ready)
         begin
            n.rdy_cnt = q.rdy_cnt + 12'h001;
            if (q.rdy_cnt == 12'(READY_CYCLES - 1))
            begin
               n.reg_ready = 1'b1;
            end
         end
         // serial port is dead until its regulator is ready
         if (q.reg_ready)
         begin
            if (q.sclk_s[1] && !q.sclk_d)
            begin
               n.shift = {q.shift[30:0], q.sdat_s[1]};
            end
            // fields change only when a whole word is latched
            if (q.sle_s[1] && !q.sle_d)
            begin
               if (addr == `PRD_REG0_ADDR)
               begin
                  n.frac_n  = q.shift[`PRD_FRAC_MSB:`PRD_FRAC_LSB];
                  n.int_n   = q.shift[`PRD_INT_MSB:`PRD_INT_LSB];
                  n.mux_sel = q.shift[`PRD_MUX_MSB:`PRD_MUX_LSB];
               end
               else if (addr == `PRD_REG1_ADDR)
               begin
                  n.rdiv   = q.shift[`PRD_RDIV_MSB:`PRD_RDIV_LSB];
                  n.ckdiv  = q.shift[`PRD_CKDIV_MSB:`PRD_CKDIV_LSB];
                  n.osc_en = q.shift[`PRD_OSCEN_BIT];
                  n.bias   = q.shift[`PRD_BIAS_MSB:`PRD_BIAS_LSB];
                  n.halve  = q.shift[`PRD_HALVE_BIT];
               end
            end
         end
         if (q.osc_run)
         begin
            if (q.rcnt >= rlim - 3'h1)
            begin
               n.rcnt    = 3'h0;
               n.pd_tick = 1'b1;
            end
            else
            begin
               n.rcnt = q.rcnt + 3'h1;
            end
         end
         if (q.pd_tick)
         begin
            // first-order sigma-delta: carry adds one to the count
            n.acc      = fsum[14:0];
            n.fb_ratio = {1'b0, q.int_n} + {8'h00, fsum[15]};
            if (phase_err_ns >= 8'(`PRD_LOCK_OUT_NS))
            begin
               n.locked   = 1'b0;
               n.lock_cnt = 3'h0;
            end
            else if (phase_err_ns < 8'(`PRD_LOCK_IN_NS))
            begin
               if (q.lock_cnt == 3'(`PRD_LOCK_RUN - 1))
               begin
                  n.locked = 1'b1;
               end
               else
               begin
                  n.lock_cnt = q.lock_cnt + 3'h1;
               end
            end
            else
            begin
               n.lock_cnt = 3'h0;
            end
         end
         case (q.mux_sel)
            PRD_MUX_REG_READY:  n.status = q.reg_ready;
            PRD_MUX_FILTER_CAL: n.status = ~filter_cal_busy;
            PRD_MUX_LOCK:       n.status = q.locked;
            PRD_MUX_RSSI:       n.status = rssi_ready;
            PRD_MUX_TX_RX:      n.status = ~tx_mode;
            default:            n.status = 1'b0;
         endcase
      end
      n.ce_s    = {q.ce_s[0], link.ce};
      n.sclk_s  = {q.sclk_s[0], link.sclk};
      n.sdat_s  = {q.sdat_s[0], link.sdata};
      n.sle_s   = {q.sle_s[0], link.sle};
      n.sclk_d  = q.sclk_s[1];
      n.sle_d   = q.sle_s[1];
      n.osc_run = q.ce_s[1] & n.osc_en;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         q <= dev_defaults();
      end
      else
      begin
         q <= n;
      end
   end

   // ************************************************************
   // divided reference clock output
   // ************************************************************
   prd_divided_ref_clock_output_div prd_divided_ref_clock_output_div_i
   (
      .mclk    (mclk),
      .reset   (reset),
      .run     (q.osc_run),
      .div     (q.ckdiv),
      .clk_out (link.divided_ref_clock_output)
   );

   assign link.status_select_pin        = q.status;
   assign osc_run                       = q.osc_run;
   assign oscillator_bias_field         = q.bias;
   assign pd_ref_tick                   = q.pd_tick;
   assign int_count                     = q.int_n;
   assign frac_value                    = q.frac_n;
   assign output_halving_select         = q.halve;
   assign fb_divide                     = q.fb_ratio;
   assign lock_detect                   = q.locked;
endmodule

// ---- rtl/prd_host.sv ----
// host end: chip enable, ready wait, 32-bit words out msb first
// and a latch pulse.
// assumes the device samples on rising sclk.
`timescale 1ns/1ps
`include "prd_params.svh"
module prd_host
   import prd_pkg::*;
#(
   parameter int SCLK_HALF = `PRD_SCLK_HALF
)
(
   input  wire logic        mclk,
   input  wire logic        reset,
   prd_link_if.host         link,
   input  wire logic        chip_enable_req,
   input  wire logic        ext_cmos_osc,
   input  wire logic        wr_valid,
   input  wire logic [31:0] wr_word,
   output      logic        wr_ready,
   output      logic        wr_done,
   output      logic        wr_refused,
   output      logic        regulator_ready,
   output      logic        status_level
);
   generate
      if (SCLK_HALF < 1 || SCLK_HALF > 255)
      begin : g_bad_half
         $error("SCLK_HALF out of range 1..255");
      end
   endgenerate

   prd_host_state_type q;
   prd_host_state_type n;

   always_comb
   begin
      logic       half_end;
      logic [3:0] addr;
      logic [7:0] intv;
      half_end = (q.divcnt == 8'(SCLK_HALF - 1));
      addr     = wr_word[`PRD_ADDR_MSB:`PRD_ADDR_LSB];
      intv     = wr_word[`PRD_INT_MSB:`PRD_INT_LSB];
      n = q;
      n.stat_s  = {q.stat_s[0], link.status_select_pin};
      n.done    = 1'b0;
      n.refused = 1'b0;
      n.ce      = chip_enable_req;
      if (!q.ce)
      begin
         n.st    = PRD_H_IDLE;
         n.rdy   = 1'b0;
         n.sel   = `PRD_RST_MUX;
         n.sclk  = 1'b0;
         n.sdata = 1'b0;
         n.sle   = 1'b0;
      end
      else
      begin
         if (q.sel == PRD_MUX_REG_READY && q.stat_s[1])
         begin
            n.rdy = 1'b1;
         end
         case (q.st)
            PRD_H_IDLE:
            begin
               if (wr_valid && q.ready_o)
               begin
                  if (addr == `PRD_REG0_ADDR && intv < 8'(`PRD_INT_MIN))
                  begin
                     n.refused = 1'b1;
                  end
                  else
                  begin
                     n.word = wr_word;
                     if (addr == `PRD_REG1_ADDR)
                     begin
                        n.word[`PRD_OSCEN_BIT] = ~ext_cmos_osc;
                     end
                     n.pend_is0 = (addr == `PRD_REG0_ADDR);
                     n.pend_sel = wr_word[`PRD_MUX_MSB:`PRD_MUX_LSB];
                     n.sdata    = n.word[31];
                     n.bitcnt   = 5'h00;
                     n.divcnt   = 8'h00;
                     n.st       = PRD_H_SHIFT;
                  end
               end
            end
            PRD_H_SHIFT:
            begin
               n.divcnt = half_end ? 8'h00 : q.divcnt + 8'h01;
               if (half_end && !q.sclk)
               begin
                  n.sclk = 1'b1;
               end
               else if (half_end)
               begin
                  n.sclk = 1'b0;
                  if (q.bitcnt == 5'h1f)
                  begin
                     n.sle = 1'b1;
                     n.st  = PRD_H_LATCH;
                  end
                  else
                  begin
                     n.bitcnt = q.bitcnt + 5'h01;
                     n.word   = {q.word[30:0], 1'b0};
                     n.sdata  = q.word[30];
                  end
               end
            end
            PRD_H_LATCH:
            begin
               n.divcnt = half_end ? 8'h00 : q.divcnt + 8'h01;
               if (half_end)
               begin
                  n.sle  = 1'b0;
                  n.done = 1'b1;
                  n.st   = PRD_H_IDLE;
                  if (q.pend_is0)
                  begin
                     n.sel = q.pend_sel;
                  end
               end
            end
            default:
            begin
               n.st = PRD_H_IDLE;
            end
         endcase
      end
      // writes only with ce high and the regulator settled
      n.ready_o = (n.st == PRD_H_IDLE) && n.ce && q.ce && n.rdy
                  && !(q.st == PRD_H_IDLE && wr_valid && q.ready_o);
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         q <= '0;
      end
      else
      begin
         q <= n;
      end
   end

   assign link.ce          = q.ce;
   assign link.sclk        = q.sclk;
   assign link.sdata       = q.sdata;
   assign link.sle         = q.sle;
   assign wr_ready         = q.ready_o;
   assign wr_done          = q.done;
   assign wr_refused       = q.refused;
   assign regulator_ready  = q.rdy;
   assign status_level     = q.stat_s[1];
endmodule

// ---- verification/prd_link_checker.sv ----
// concurrent checks on the serial link.
// assumes one mclk domain, sync active-high reset.
`timescale 1ns/1ps
module prd_link_checker
#(
   parameter int READY_CYCLES = 2000
)
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic sle,
   input wire logic status_select_pin,
   input wire logic divided_ref_clock_output
);
   int   ce_cnt;
   int   bits;
   logic wrote;
   logic sle_d;
   logic sclk_d;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   // ****************************************
   // helper counters
   // ****************************************
   always_ff @(posedge mclk)
   begin
      sle_d  <= sle;
      sclk_d <= sclk;
      if (reset || !ce)
      begin
         ce_cnt <= 0;
         bits   <= 0;
         wrote  <= 1'b0;
      end
      else
      begin
         ce_cnt <= ce_cnt + 1;
         wrote  <= wrote | (sle & ~sle_d);
         if (sle && !sle_d)
            bits <= 0;
         else if (sclk && !sclk_d)
            bits <= bits + 1;
      end
   end

   // ****************************************
   // sequences and assertions
   // ****************************************
   sequence ce_gone;
      !ce [*6];
   endsequence

   sequence le_rise;
      sle && !sle_d;
   endsequence

   a_ce_clk_off: assert property
      (ce_gone |-> !divided_ref_clock_output)
      else $error("clock output with ce low");
   a_ce_stat_off: assert property (ce_gone |-> !status_select_pin)
      else $error("status high with ce low");
   a_shift_ce: assert property ($rose(sclk) |-> ce)
      else $error("sclk with ce low");
   a_latch_ce: assert property
      (le_rise |-> ce && ce_cnt >= READY_CYCLES)
      else $error("latch before regulator ready");
   a_wait_ready: assert property
      ($rose(sclk) |-> ce_cnt >= READY_CYCLES)
      else $error("shift before regulator ready");
   a_ready_early: assert property ($rose(status_select_pin) && !wrote
      |-> ce_cnt >= READY_CYCLES)
      else $error("regulator ready rose too early");
   a_ready_late: assert property (ce && ce_cnt == READY_CYCLES + 8 && !wrote
      |-> status_select_pin)
      else $error("regulator ready missing on status pin");
   a_word_whole: assert property (le_rise |-> bits == 32)
      else $error("latch without a whole word");
   a_data_stable: assert property
      (sclk && sclk_d |-> $stable(sdata))
      else $error("serial data moved while clock high");
endmodule

// ---- verification/pll_reference_divider_control_bench.sv ----
// self-checking bench of both ends.
// assumes design and checker files compiled first.
`timescale 1ns/1ps
module pll_reference_divider_control_bench
   import prd_pkg::*;
;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic        chip_enable_req = 1'b0;
   logic        ext_cmos_osc = 1'b0;
   logic        wr_valid = 1'b0;
   logic [31:0] wr_word = 32'h0;
   logic [7:0]  phase_err_ns = 8'h1e;
   logic        filter_cal_busy = 1'b0;
   logic        rssi_ready = 1'b0;
   logic        tx_mode = 1'b0;
   logic        wr_ready, wr_done, wr_refused, regulator_ready;
   logic        status_level, osc_run, pd_ref_tick, halve, lock_detect;
   logic [1:0]  bias;
   logic [7:0]  int_count;
   logic [14:0] frac_value;
   logic [8:0]  fb_divide;
   int          n_mismatch = 0;
   int          compares = 0;

   always #12.5 mclk = ~mclk;

   prd_link_if link();
   prd_device #(.READY_CYCLES(10)) prd_device_i (.mclk(mclk), .reset(reset),
      .link(link), .phase_err_ns(phase_err_ns),
      .filter_cal_busy(filter_cal_busy), .rssi_ready(rssi_ready),
      .tx_mode(tx_mode), .osc_run(osc_run), .oscillator_bias_field(bias),
      .pd_ref_tick(pd_ref_tick), .int_count(int_count),
      .frac_value(frac_value), .output_halving_select(halve),
      .fb_divide(fb_divide), .lock_detect(lock_detect));
   prd_host prd_host_i (.mclk(mclk), .reset(reset), .link(link),
      .chip_enable_req(chip_enable_req), .ext_cmos_osc(ext_cmos_osc),
      .wr_valid(wr_valid), .wr_word(wr_word), .wr_ready(wr_ready),
      .wr_done(wr_done), .wr_refused(wr_refused),
      .regulator_ready(regulator_ready), .status_level(status_level));
   prd_link_checker #(.READY_CYCLES(10)) prd_link_checker_i (.mclk(mclk),
      .reset(reset), .ce(link.ce), .sclk(link.sclk), .sdata(link.sdata),
      .sle(link.sle), .status_select_pin(link.status_select_pin),
      .divided_ref_clock_output(link.divided_ref_clock_output));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic end_sim();
      if (n_mismatch == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic hung(input string nm);
      n_mismatch++;
      $display("Error %s expected event seen timeout", nm);
      end_sim();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   function automatic logic [31:0] r0(logic [2:0] m, logic [7:0] i,
                                      logic [14:0] f);
      return {m, 2'h0, i, f, 4'h0};
   endfunction

   function automatic logic [31:0] r1(logic h, logic [1:0] b, logic o,
                                      logic [3:0] c, logic [2:0] r);
      return {13'h0, h, 3'h0, b, o, 1'b0, c, r, 4'h1};
   endfunction

   task automatic wr(input logic [31:0] w, input logic exp_ref);
      logic [7:0] old;
      int         k;
      for (k = 0; k < 400 && wr_ready !== 1'b1; k++)
         @(negedge mclk);
      if (wr_ready !== 1'b1)
         hung("wr_ready");
      old = int_count;
      wr_word = w;
      wr_valid = 1'b1;
      @(negedge mclk);
      wr_valid = 1'b0;
      for (k = 0; k < 400 && wr_done !== 1'b1 && wr_refused !== 1'b1; k++)
      begin
         @(negedge mclk);
         if (k == 20)
            chk("int_mid_word", int_count, old);
      end
      if (wr_done !== 1'b1 && wr_refused !== 1'b1)
         hung("wr_done");
      chk("wr_refused", wr_refused, exp_ref);
      cyc(6);
   endtask

   task automatic power_up();
      int k;
      chip_enable_req = 1'b1;
      for (k = 0; k < 200 && regulator_ready !== 1'b1; k++)
         @(negedge mclk);
      if (regulator_ready !== 1'b1)
         hung("regulator_ready");
      chk("status_ready", link.status_select_pin, 1'b1);
      chk("status_level", status_level, 1'b1);
   endtask

   task automatic runs(output int hi, output int lo);
      hi = 0;
      lo = 0;
      for (int k = 0; k < 80 && link.divided_ref_clock_output !== 1'b0; k++)
         @(negedge mclk);
      for (int k = 0; k < 80 && link.divided_ref_clock_output !== 1'b1; k++)
         @(negedge mclk);
      for (; hi < 80 && link.divided_ref_clock_output === 1'b1; hi++)
         @(negedge mclk);
      for (; lo < 80 && link.divided_ref_clock_output === 1'b0; lo++)
         @(negedge mclk);
   endtask

   task automatic tick_gap(output int g);
      for (int k = 0; k < 20 && pd_ref_tick !== 1'b1; k++)
         @(negedge mclk);
      g = 0;
      do
      begin
         @(negedge mclk);
         g++;
      end
      while (pd_ref_tick !== 1'b1 && g < 20);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_defaults();
      int hi, lo, g;
      chk("clk_off", link.divided_ref_clock_output, 1'b0);
      chk("status_off", link.status_select_pin, 1'b0);
      power_up();
      chk("osc_run", osc_run, 1'b1);
      runs(hi, lo);
      chk("clk_hi", hi, 4);
      chk("clk_lo", lo, 4);
      tick_gap(g);
      chk("pd_gap", g, 1);
   endtask

   task automatic t_ref_path();
      int hi, lo, g;
      logic [3:0] ck [2] = '{4'h1, 4'hf};
      logic [2:0] rd [2] = '{3'h7, 3'h3};
      for (int i = 0; i < 2; i++)
      begin
         wr(r1(1'b1, 2'h3, 1'b1, ck[i], rd[i]), 1'b0);
         runs(hi, lo);
         chk("clk_hi", hi, ck[i]);
         chk("clk_lo", lo, ck[i]);
         tick_gap(g);
         chk("pd_gap", g, rd[i]);
         chk("bias", bias, 2'h3);
         chk("halve", halve, 1'b1);
      end
      wr(r1(1'b0, 2'h0, 1'b1, 4'h0, 3'h1), 1'b0);
      repeat (4)
      begin
         cyc(7);
         chk("clk_disabled", link.divided_ref_clock_output, 1'b0);
      end
   endtask

   task automatic t_feedback();
      int sum;
      wr(r0(3'h0, 8'd23, 15'h0), 1'b0);
      chk("int", int_count, 8'd23);
      cyc(3);
      chk("fb", fb_divide, 9'd23);
      wr(r0(3'h0, 8'd255, 15'h4000), 1'b0);
      chk("frac", frac_value, 15'h4000);
      sum = 0;
      repeat (8)
      begin
         @(negedge mclk);
         sum += fb_divide;
      end
      chk("fb_sum", sum, 2044);
      wr(r0(3'h0, 8'd22, 15'h0), 1'b1);
      chk("int_kept", int_count, 8'd255);
   endtask

   task automatic t_status();
      logic e;
      for (int c = 1; c < 6; c++)
      begin
         wr(r0(c[2:0], 8'd23, 15'h0), 1'b0);
         for (int b = 0; b < 2; b++)
         begin
            {filter_cal_busy, rssi_ready, tx_mode} = {3{b[0]}};
            phase_err_ns = b[0] ? 8'd0 : 8'd30;
            cyc(10);
            e = (c == 5) ? 1'b0 : ((c == 1 || c == 4) ? ~b[0] : b[0]);
            chk("status_sel", link.status_select_pin, e);
         end
      end
      wr(r0(3'h2, 8'd23, 15'h0), 1'b0);
      phase_err_ns = 8'd30;
      cyc(4);
      phase_err_ns = 8'd0;
      cyc(3);
      chk("lock_early", link.status_select_pin, 1'b0);
      cyc(6);
      chk("lock_set", link.status_select_pin, 1'b1);
      chk("lock_flag", lock_detect, 1'b1);
      phase_err_ns = 8'd20;
      cyc(6);
      chk("lock_held", link.status_select_pin, 1'b1);
      phase_err_ns = 8'd25;
      cyc(4);
      chk("lock_lost", link.status_select_pin, 1'b0);
      wr(r0(3'h1, 8'd23, 15'h0), 1'b0);
      filter_cal_busy = 1'b1;
      cyc(4);
      chk("cal_busy", link.status_select_pin, 1'b0);
      filter_cal_busy = 1'b0;
      cyc(4);
      chk("cal_done", link.status_select_pin, 1'b1);
   endtask

   task automatic t_cmos_and_ce();
      int hi, lo, g;
      ext_cmos_osc = 1'b1;
      wr(r1(1'b1, 2'h2, 1'b1, 4'h2, 3'h5), 1'b0);
      chk("osc_cmos", osc_run, 1'b0);
      cyc(8);
      chk("clk_cmos", link.divided_ref_clock_output, 1'b0);
      ext_cmos_osc = 1'b0;
      chip_enable_req = 1'b0;
      cyc(10);
      chk("osc_ce", osc_run, 1'b0);
      chk("wr_ready_ce", wr_ready, 1'b0);
      power_up();
      chk("bias_clr", bias, 2'h0);
      chk("halve_clr", halve, 1'b0);
      chk("int_clr", int_count, 8'h00);
      runs(hi, lo);
      chk("clk_clr", hi, 4);
      tick_gap(g);
      chk("pd_clr", g, 1);
   endtask

   initial
   begin
      repeat (20) @(negedge mclk);
      reset = 1'b0;
      t_defaults();
      t_ref_path();
      t_feedback();
      t_status();
      t_cmos_and_ce();
      end_sim();
   end

   initial
   begin
      #1500000;
      hung("run");
   end
endmodule
